/* rtl/ovf_msg_pkg.sv */
// shared constants and types for the message flag and overflow mode bank
package ovf_msg_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = ADDR_W - 2;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STATUS2  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_OVF      = 6'h03;
  localparam logic [IDX_W-1:0] IDX_DEST     = 6'h04;
  localparam logic [IDX_W-1:0] IDX_MATHREG  = 6'h05;

  // status word two field positions
  localparam int BIT_INCOMING  = 5;
  localparam int BIT_REPLY     = 6;
  localparam int BIT_OUTGOING  = 7;
  localparam int BIT_OVF_MODE  = 14;
  localparam int STATUS_W      = 16;
  localparam int BYTE_OVF_MODE = BIT_OVF_MODE / 8;

  // overflow status register field positions
  localparam int OVF_BIT_FLAG  = 0;
  localparam int OVF_BIT_TRAP  = 1;
  localparam int BYTE_OVF      = 0;

  // reset value of the overflow mode bit: saturate
  localparam logic OVF_MODE_RESET = 1'b0;

  // saturation limits of a 16-bit signed destination
  localparam logic signed [31:0] LIM_MAX = 32'sh00007FFF;
  localparam logic signed [31:0] LIM_MIN = 32'shFFFF8000;
  localparam logic [15:0]        SAT_MAX = 16'h7FFF;
  localparam logic [15:0]        SAT_MIN = 16'h8000;

  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    OP_ADD,
    OP_SUB,
    OP_MUL,
    OP_DIV,
    OP_DDV
  } mathOp_e;

endpackage

/* rtl/msg_flag_tracker.sv */
// communication pending flags of status word two
module msg_flag_tracker (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // events from the communication engine
  input  wire logic remoteRequest,
  input  wire logic remoteServiced,
  input  wire logic replyArrived,
  input  wire logic replyStored,
  input  wire logic msgQueued,
  input  wire logic txStart,
  input  wire logic txDone,
  // flags
  output logic      incomingPending,
  output logic      replyPending,
  output logic      outgoingPending,
  output logic      txBusy
);

  logic incomingNxt;
  logic replyNxt;
  logic busyNxt;
  logic outgoingNxt;

  // a new event in the clearing cycle keeps the flag set
  assign incomingNxt = remoteRequest | (incomingPending & ~remoteServiced);
  assign replyNxt    = replyArrived | (replyPending & ~replyStored);
  assign busyNxt     = txStart | (txBusy & ~txDone);
  // pending only while something waits and nothing is on the wire
  assign outgoingNxt = ~txStart & msgQueued & ~busyNxt;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      incomingPending <= 1'b0;
      replyPending    <= 1'b0;
      outgoingPending <= 1'b0;
      txBusy          <= 1'b0;
    end else begin
      incomingPending <= incomingNxt;
      replyPending    <= replyNxt;
      outgoingPending <= outgoingNxt;
      txBusy          <= busyNxt;
    end
  end

endmodule // msg_flag_tracker

/* rtl/ovf_resolver.sv */
// resolves arithmetic results into a 16-bit destination per overflow mode
module ovf_resolver (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  // result from the arithmetic unit
  input  wire logic                    opValid,
  input  wire ovf_msg_pkg::mathOp_e    opKind,
  input  wire logic signed [31:0]      rawResult,
  input  wire logic                    overflowMode,
  // flag clears from software
  input  wire logic                    clrFlag,
  input  wire logic                    clrTrap,
  // outputs
  output logic [15:0]                  destValue,
  output logic                         destValid,
  output logic [31:0]                  mathRegValue,
  output logic                         overflowFlag,
  output logic                         overflowTrap
);
  import ovf_msg_pkg::*;

  logic        tooBig;
  logic        tooSmall;
  logic        overflow;
  logic        useTrunc;
  logic [15:0] satValue;
  logic [15:0] resolved;
  logic        mathRegWrite;

  assign tooBig   = rawResult > LIM_MAX;
  assign tooSmall = rawResult < LIM_MIN;
  assign overflow = tooBig | tooSmall;
  // double divide ignores the mode and always saturates
  assign useTrunc = overflowMode & (opKind != OP_DDV);
  assign satValue = tooBig ? SAT_MAX : SAT_MIN;
  assign resolved = (overflow & ~useTrunc) ? satValue : rawResult[15:0];
  // math register is written from the raw result, never from the mode
  assign mathRegWrite = opValid & ((opKind == OP_MUL) | (opKind == OP_DIV));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      destValue    <= 16'h0000;
      destValid    <= 1'b0;
      mathRegValue <= 32'h00000000;
      overflowFlag <= 1'b0;
      overflowTrap <= 1'b0;
    end else begin
      destValid <= opValid;
      if (opValid) begin
        destValue <= resolved;
      end
      if (mathRegWrite) begin
        mathRegValue <= rawResult;
      end
      overflowFlag <= (opValid & overflow) | (overflowFlag & ~clrFlag);
      overflowTrap <= (opValid & overflow) | (overflowTrap & ~clrTrap);
    end
  end

endmodule // ovf_resolver

/* rtl/msg_flags_and_overflow_mode.sv */
// status word two bank: message pending flags and overflow mode, AXI4-Lite slave
// Operation
// - the incoming-request flag sets whenever a remote node asks for data or sends a command.
// - the incoming-request flag clears once that remote request has been serviced.
// - the reply-pending flag sets when a remote node returns data a local message asked for.
// - the reply-pending flag clears after the data is stored and the message status updated.
// - the outgoing-pending flag is set while a message is queued and none is transmitting.
// - the outgoing-pending flag clears at the moment a transmission starts.
// - after a transmission the outgoing flag sets again only if more messages are queued.
// - any arithmetic result that does not fit sets both the overflow bit and the trap bit.
// - with the mode bit set, an overflowing result other than a double divide is written as its low 16 bits.
// - with the mode bit clear, an overflowing result saturates to 32767 or -32768.
// - the overflow mode bit resets to zero, selecting saturation.
// - the double divide instruction behaves the same whatever the mode bit says.
// - multiply and divide leave the same math register value in either mode.
module msg_flags_and_overflow_mode (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rst_b,
  // write address channel
  input  wire logic [ovf_msg_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                           awvalid,
  output logic                                awready,
  // write data channel
  input  wire logic [ovf_msg_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  // write response channel
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  // read address channel
  input  wire logic [ovf_msg_pkg::ADDR_W-1:0] araddr,
  input  wire logic                           arvalid,
  output logic                                arready,
  // read data channel
  output logic [ovf_msg_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  // communication engine events
  input  wire logic                           remoteRequest,
  input  wire logic                           remoteServiced,
  input  wire logic                           replyArrived,
  input  wire logic                           replyStored,
  input  wire logic                           msgQueued,
  input  wire logic                           txStart,
  input  wire logic                           txDone,
  // arithmetic unit result
  input  wire logic                           opValid,
  input  wire ovf_msg_pkg::mathOp_e           opKind,
  input  wire logic signed [31:0]             rawResult,
  // status to the controller core
  output logic                                incomingPending,
  output logic                                replyPending,
  output logic                                outgoingPending,
  output logic                                txBusy,
  output logic                                overflowMode,
  // resolved arithmetic outputs
  output logic [15:0]                         destValue,
  output logic                                destValid,
  output logic [31:0]                         mathRegValue,
  output logic                                overflowFlag,
  output logic                                overflowTrap
);
  import ovf_msg_pkg::*;

  // register index taken from a byte address
  function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] addr);
    regIndex = addr[ADDR_W-1:2];
  endfunction

  // only the four words of the bank answer okay
  function automatic logic isMapped(input logic [IDX_W-1:0] idx);
    isMapped = (idx == IDX_STATUS2) | (idx == IDX_OVF) |
               (idx == IDX_DEST) | (idx == IDX_MATHREG);
  endfunction

  // write side state
  logic                 awHeld_r;
  logic                 awHeld_nxt;
  logic [ADDR_W-1:0]    awAddr_r;
  logic                 wHeld_r;
  logic                 wHeld_nxt;
  logic [DATA_W-1:0]    wData_r;
  logic [3:0]           wStrb_r;
  logic                 awReady_r;
  logic                 wReady_r;
  logic                 bValid_r;
  logic                 bValid_nxt;
  logic [1:0]           bResp_r;

  // read side state
  logic                 arReady_r;
  logic                 rValid_r;
  logic                 rValid_nxt;
  logic [DATA_W-1:0]    rData_r;
  logic [1:0]           rResp_r;

  // configuration
  logic                 overflowMode_r;
  logic                 overflowMode_nxt;

  // handshakes and decode
  logic                 awTake;
  logic                 wTake;
  logic                 arTake;
  logic                 doWrite;
  logic [IDX_W-1:0]     wrIdx;
  logic [IDX_W-1:0]     rdIdx;
  logic                 wrMapped;
  logic                 rdMapped;
  logic                 wrStatus;
  logic                 wrOvf;
  logic                 clrFlag;
  logic                 clrTrap;

  // read assembly
  logic [STATUS_W-1:0]  statusWord;
  logic [DATA_W-1:0]    ovfWord;
  logic [DATA_W-1:0]    readData;

  // resolver outputs
  logic [15:0]          destValueW;
  logic                 destValidW;
  logic [31:0]          mathRegW;
  logic                 ovfFlagW;
  logic                 ovfTrapW;

  // tracker outputs
  logic                 incomingW;
  logic                 replyW;
  logic                 outgoingW;
  logic                 busyW;

  // write channel handshakes
  assign awTake     = awvalid & awReady_r;
  assign wTake      = wvalid & wReady_r;
  assign doWrite    = awHeld_r & wHeld_r & ~bValid_r;
  assign awHeld_nxt = doWrite ? 1'b0 : (awHeld_r | awTake);
  assign wHeld_nxt  = doWrite ? 1'b0 : (wHeld_r | wTake);
  assign bValid_nxt = doWrite | (bValid_r & ~bready);

  // write decode
  assign wrIdx    = regIndex(awAddr_r);
  assign wrMapped = isMapped(wrIdx);
  assign wrStatus = doWrite & (wrIdx == IDX_STATUS2);
  assign wrOvf    = doWrite & (wrIdx == IDX_OVF) & wStrb_r[BYTE_OVF];

  // only the mode bit of the status word is writable
  assign overflowMode_nxt = (wrStatus & wStrb_r[BYTE_OVF_MODE]) ?
                            wData_r[BIT_OVF_MODE] : overflowMode_r;

  // overflow flags clear by writing one
  assign clrFlag = wrOvf & wData_r[OVF_BIT_FLAG];
  assign clrTrap = wrOvf & wData_r[OVF_BIT_TRAP];

  // read channel handshakes and decode
  assign arTake     = arvalid & arReady_r;
  assign rValid_nxt = arTake | (rValid_r & ~rready);
  assign rdIdx      = regIndex(araddr);
  assign rdMapped   = isMapped(rdIdx);

  // status word with reserved positions held at zero
  always_comb begin
    statusWord               = '0;
    statusWord[BIT_INCOMING] = incomingW;
    statusWord[BIT_REPLY]    = replyW;
    statusWord[BIT_OUTGOING] = outgoingW;
    statusWord[BIT_OVF_MODE] = overflowMode_r;
  end

  always_comb begin
    ovfWord               = '0;
    ovfWord[OVF_BIT_FLAG] = ovfFlagW;
    ovfWord[OVF_BIT_TRAP] = ovfTrapW;
  end

  assign readData = (rdIdx == IDX_STATUS2) ? {16'h0000, statusWord} :
                    (rdIdx == IDX_OVF)     ? ovfWord :
                    (rdIdx == IDX_DEST)    ? {16'h0000, destValueW} :
                    (rdIdx == IDX_MATHREG) ? mathRegW :
                    32'h00000000;

  // write address and data capture
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r  <= 1'b0;
      awAddr_r  <= '0;
      awReady_r <= 1'b0;
    end else begin
      awHeld_r  <= awHeld_nxt;
      awReady_r <= ~awHeld_nxt;
      if (awTake) begin
        awAddr_r <= awaddr;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_r  <= 1'b0;
      wData_r  <= '0;
      wStrb_r  <= 4'h0;
      wReady_r <= 1'b0;
    end else begin
      wHeld_r  <= wHeld_nxt;
      wReady_r <= ~wHeld_nxt;
      if (wTake) begin
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
    end else begin
      bValid_r <= bValid_nxt;
      if (doWrite) begin
        bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // mode bit, saturation after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overflowMode_r <= OVF_MODE_RESET;
    end else begin
      overflowMode_r <= overflowMode_nxt;
    end
  end

  // read answer, one word at a time
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arReady_r <= 1'b0;
      rValid_r  <= 1'b0;
      rData_r   <= '0;
      rResp_r   <= RESP_OKAY;
    end else begin
      arReady_r <= ~rValid_nxt;
      rValid_r  <= rValid_nxt;
      if (arTake) begin
        rData_r <= readData;
        rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // output registers of the core-facing status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      incomingPending <= 1'b0;
      replyPending    <= 1'b0;
      outgoingPending <= 1'b0;
      txBusy          <= 1'b0;
      overflowMode    <= OVF_MODE_RESET;
    end else begin
      incomingPending <= incomingW;
      replyPending    <= replyW;
      outgoingPending <= outgoingW;
      txBusy          <= busyW;
      overflowMode    <= overflowMode_r;
    end
  end

  // output registers of the arithmetic path
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      destValue    <= 16'h0000;
      destValid    <= 1'b0;
      mathRegValue <= 32'h00000000;
      overflowFlag <= 1'b0;
      overflowTrap <= 1'b0;
    end else begin
      destValue    <= destValueW;
      destValid    <= destValidW;
      mathRegValue <= mathRegW;
      overflowFlag <= ovfFlagW;
      overflowTrap <= ovfTrapW;
    end
  end

  assign awready = awReady_r;
  assign wready  = wReady_r;
  assign bvalid  = bValid_r;
  assign bresp   = bResp_r;
  assign arready = arReady_r;
  assign rvalid  = rValid_r;
  assign rdata   = rData_r;
  assign rresp   = rResp_r;

  msg_flag_tracker u_flags (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .remoteRequest   (remoteRequest),
    .remoteServiced  (remoteServiced),
    .replyArrived    (replyArrived),
    .replyStored     (replyStored),
    .msgQueued       (msgQueued),
    .txStart         (txStart),
    .txDone          (txDone),
    .incomingPending (incomingW),
    .replyPending    (replyW),
    .outgoingPending (outgoingW),
    .txBusy          (busyW)
  );

  ovf_resolver u_ovf (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .opValid      (opValid),
    .opKind       (opKind),
    .rawResult    (rawResult),
    .overflowMode (overflowMode_r),
    .clrFlag      (clrFlag),
    .clrTrap      (clrTrap),
    .destValue    (destValueW),
    .destValid    (destValidW),
    .mathRegValue (mathRegW),
    .overflowFlag (ovfFlagW),
    .overflowTrap (ovfTrapW)
  );

endmodule // msg_flags_and_overflow_mode

/* verif/msg_flags_props.sv */
// concurrent checks on the ports of the message flag and overflow mode bank
module msg_flags_props
  import ovf_msg_pkg::*;
(
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_b,
  // communication events
  input wire logic                 remoteRequest,
  input wire logic                 remoteServiced,
  input wire logic                 replyArrived,
  input wire logic                 replyStored,
  input wire logic                 msgQueued,
  input wire logic                 txStart,
  input wire logic                 txDone,
  // arithmetic result
  input wire logic                 opValid,
  input wire ovf_msg_pkg::mathOp_e opKind,
  input wire logic signed [31:0]   rawResult,
  // outputs under watch
  input wire logic                 incomingPending,
  input wire logic                 replyPending,
  input wire logic                 outgoingPending,
  input wire logic                 overflowMode,
  input wire logic [15:0]          destValue,
  input wire logic                 destValid,
  input wire logic [31:0]          mathRegValue,
  input wire logic                 overflowFlag,
  input wire logic                 overflowTrap
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic        ovfIn  = (rawResult > LIM_MAX) || (rawResult < LIM_MIN);
  wire logic        satSel = !overflowMode || (opKind == OP_DDV);
  wire logic [15:0] rawLow = rawResult[15:0];

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_incoming_set: assert property (remoteRequest |-> ##2 incomingPending)
    else $error("incoming flag did not set");
  a_incoming_clr: assert property (remoteServiced && !remoteRequest |-> ##2 !incomingPending)
    else $error("incoming flag did not clear");
  a_reply_set: assert property (replyArrived |-> ##2 replyPending)
    else $error("reply flag did not set");
  a_reply_clr: assert property (replyStored && !replyArrived |-> ##2 !replyPending)
    else $error("reply flag did not clear");
  a_out_start: assert property (txStart |-> ##2 !outgoingPending)
    else $error("outgoing flag stayed set at start");
  a_out_again: assert property (txDone && !txStart && msgQueued |-> ##2 outgoingPending)
    else $error("outgoing flag not set after transmission");
  a_out_empty: assert property (txDone && !msgQueued |-> ##2 !outgoingPending)
    else $error("outgoing flag set with empty queue");
  a_ovf_flags: assert property (opValid && ovfIn |-> ##2 overflowFlag && overflowTrap)
    else $error("overflow flags not both set");
  a_trunc_mode: assert property (opValid && ovfIn && !satSel |->
    ##2 destValid && destValue == $past(rawLow, 2))
    else $error("truncated destination wrong");
  a_sat_high: assert property (opValid && rawResult > LIM_MAX && satSel |->
    ##2 destValid && destValue == SAT_MAX)
    else $error("positive saturation wrong");
  a_sat_low: assert property (opValid && rawResult < LIM_MIN && satSel |->
    ##2 destValid && destValue == SAT_MIN)
    else $error("negative saturation wrong");
  a_math_reg: assert property (opValid && (opKind == OP_MUL || opKind == OP_DIV) |->
    ##2 mathRegValue == $past(rawResult, 2))
    else $error("math register wrong");
endmodule // msg_flags_props

/* verif/net_node_model.sv */
// far-side model: remote nodes, reply traffic and the outgoing message queue
module net_node_model (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // bench command: 1 request 2 serviced 3 reply 4 stored 5 start 6 done 7 enqueue
  input wire logic [2:0] cmd,
  // events toward the bank
  output logic           remoteRequest,
  output logic           remoteServiced,
  output logic           replyArrived,
  output logic           replyStored,
  output logic           msgQueued,
  output logic           txStart,
  output logic           txDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] queueCnt_r;
  wire logic [7:0] cmdHot = 8'h01 << cmd;

  // queue level only, the bank must work out busy itself
  assign msgQueued = (queueCnt_r != 4'h0);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {txDone, txStart, replyStored, replyArrived, remoteServiced, remoteRequest} <= 6'h00;
      queueCnt_r <= 4'h0;
    end else begin
      {txDone, txStart, replyStored, replyArrived, remoteServiced, remoteRequest} <= cmdHot[6:1];
      queueCnt_r <= queueCnt_r + {3'h0, cmdHot[7]} - {3'h0, cmdHot[5]};
    end
  end
endmodule // net_node_model

/* verif/msg_flags_and_overflow_mode_tb.sv */
// self-checking bench for the message flag and overflow mode bank
module msg_flags_and_overflow_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ovf_msg_pkg::*;

  logic               mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, opValid, destValid, txBusy;
  logic               remoteRequest, remoteServiced, replyArrived, replyStored;
  logic               msgQueued, txStart, txDone, incomingPending, replyPending;
  logic               outgoingPending, overflowMode, overflowFlag, overflowTrap;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, mathRegValue, lfsr, expMath;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic [2:0]         cmd;
  logic [15:0]        destValue;
  logic signed [31:0] rawResult;
  mathOp_e            opKind;
  int                 miscompares, checked;
  logic signed [31:0] corner [6] = '{32'h00007FFF, 32'h00008000, 32'hFFFF8000,
                                     32'hFFFF7FFF, 32'h000186A0, 32'hFFFE7960};

  msg_flags_and_overflow_mode msg_flags_and_overflow_mode_i (.mclk, .rst_b, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .remoteRequest, .remoteServiced, .replyArrived,
    .replyStored, .msgQueued, .txStart, .txDone, .opValid, .opKind, .rawResult, .incomingPending,
    .replyPending, .outgoingPending, .txBusy, .overflowMode, .destValue, .destValid,
    .mathRegValue, .overflowFlag, .overflowTrap);

  net_node_model net_node_model_i (.mclk, .rst_b, .cmd, .remoteRequest, .remoteServiced,
    .replyArrived, .replyStored, .msgQueued, .txStart, .txDone);

  always #10 mclk = ~mclk;

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [15:0] exp_dest(input mathOp_e k, input logic signed [31:0] v,
                                           input logic m);
    if (v > LIM_MAX) return (m && k != OP_DDV) ? v[15:0] : SAT_MAX;
    if (v < LIM_MIN) return (m && k != OP_DDV) ? v[15:0] : SAT_MIN;
    return v[15:0];
  endfunction

  task automatic print_verdict;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang;
    miscompares++;
    print_verdict;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 50) hang();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 50) hang();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic ev(input logic [2:0] k);
    @(posedge mclk);
    cmd <= k;
    @(posedge mclk);
    cmd <= 3'h0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic do_op(input mathOp_e k, input logic signed [31:0] v, input logic md);
    int n;
    logic o;
    o = (v > LIM_MAX) || (v < LIM_MIN);
    if (k == OP_MUL || k == OP_DIV) expMath = v;
    repeat (2) @(posedge mclk);
    opValid <= 1'b1;
    opKind <= k;
    rawResult <= v;
    @(posedge mclk);
    opValid <= 1'b0;
    n = 0;
    while (destValid !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 20) hang();
    end
    chk({31'h0, overflowMode}, {31'h0, md});
    chk({16'h0, destValue}, {16'h0, exp_dest(k, v, md)});
    chk(mathRegValue, expMath);
    chk({30'h0, overflowFlag, overflowTrap}, {30'h0, o, o});
  endtask

  initial begin
    logic               m;
    logic signed [31:0] v;
    {mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, opValid} = 8'h00;
    {awaddr, araddr, wdata, wstrb, cmd} = '0;
    opKind = OP_ADD;
    rawResult = 32'h00000000;
    miscompares = 0;
    checked = 0;
    lfsr = 32'h000179CE;
    expMath = 32'h00000000;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    rd_chk(8'h40, 32'h00000000, RESP_SLVERR);
    wr(8'h08, 32'hFFFFFFFF, 4'h1, RESP_OKAY);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    wr(8'h08, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    rd_chk(8'h08, 32'h00004000, RESP_OKAY);
    wr(8'h08, 32'h00000000, 4'hF, RESP_OKAY);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    wr(8'h10, 32'h0000FFFF, 4'hF, RESP_OKAY);
    rd_chk(8'h10, 32'h00000000, RESP_OKAY);
    ev(3'h1);
    rd_chk(8'h08, 32'h00000020, RESP_OKAY);
    ev(3'h2);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    ev(3'h3);
    rd_chk(8'h08, 32'h00000040, RESP_OKAY);
    ev(3'h4);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    ev(3'h7);
    rd_chk(8'h08, 32'h00000080, RESP_OKAY);
    ev(3'h5);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    chk({31'h0, txBusy}, 32'h00000001);
    ev(3'h7);
    ev(3'h7);
    ev(3'h5);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    ev(3'h6);
    rd_chk(8'h08, 32'h00000080, RESP_OKAY);
    chk({31'h0, txBusy}, 32'h00000000);
    ev(3'h5);
    ev(3'h6);
    rd_chk(8'h08, 32'h00000000, RESP_OKAY);
    for (int i = 0; i < 60; i++) begin
      lfsr = nxt(lfsr);
      m = (i < 12) ? (i >= 6) : lfsr[0];
      v = (i < 12) ? corner[i % 6] : $signed(lfsr) >>> (lfsr[7:5] + 13);
      wr(8'h08, {17'h0, m, 14'h0}, 4'h2, RESP_OKAY);
      wr(8'h0C, 32'h00000003, 4'h1, RESP_OKAY);
      do_op(mathOp_e'(i % 5), v, m);
    end
    do_op(OP_ADD, 32'h00009C40, m);
    rd_chk(8'h0C, 32'h00000003, RESP_OKAY);
    rd_chk(8'h10, {16'h0, exp_dest(OP_ADD, 32'h00009C40, m)}, RESP_OKAY);
    rd_chk(8'h14, expMath, RESP_OKAY);
    wr(8'h0C, 32'h00000003, 4'h1, RESP_OKAY);
    rd_chk(8'h0C, 32'h00000000, RESP_OKAY);
    print_verdict;
  end
endmodule // msg_flags_and_overflow_mode_tb

bind msg_flags_and_overflow_mode msg_flags_props msg_flags_props_i (.mclk, .rst_b,
  .remoteRequest, .remoteServiced, .replyArrived, .replyStored, .msgQueued, .txStart, .txDone,
  .opValid, .opKind, .rawResult, .incomingPending, .replyPending, .outgoingPending,
  .overflowMode, .destValue, .destValid, .mathRegValue, .overflowFlag, .overflowTrap);
